// ---- src/sssiu_consts.vh ----
`ifndef SSSIU_CONSTS_VH
`define SSSIU_CONSTS_VH

// ****************************************************
// Instruction field positions
// ****************************************************
`define SSSIU_F_OPC 31:26
`define SSSIU_F_RS  25:21
`define SSSIU_F_RT  20:16
`define SSSIU_F_RD  15:11
`define SSSIU_F_SA  10:6
`define SSSIU_F_FN  5:0
`define SSSIU_QUIET_BIT 22

// ****************************************************
// Opcodes, function codes and formats
// ****************************************************
`define SSSIU_OP_PRIMARY_OPCODE_ZERO_CLASS 6'h00
`define SSSIU_OP_FP_COPROCESSOR_OPCODE    6'h11
`define SSSIU_FN_SLL     6'h00
`define SSSIU_FN_SRL     6'h02
`define SSSIU_FN_SRA     6'h03
`define SSSIU_FN_SHIFT_RIGHT_LOGIC_VAR    6'h06
`define SSSIU_FN_SHIFT_RIGHT_ARITH_VAR    6'h07
`define SSSIU_FN_SUB     6'h22
`define SSSIU_FN_UNSIGNED_LESS_THAN_SET    6'h2B
`define SSSIU_FN_FP_SQUARE_ROOT    6'h04
`define SSSIU_FMT_S      5'h10
`define SSSIU_FMT_D      5'h11
`define SSSIU_SSNOP      32'h00000040

// ****************************************************
// Rounding modes and float constants
// ****************************************************
`define SSSIU_RM_NEAR    2'h0
`define SSSIU_RM_ZERO    2'h1
`define SSSIU_RM_PLUS    2'h2
`define SSSIU_RM_MINUS   2'h3
`define SSSIU_EXP_MAX    8'hFF
`define SSSIU_EXP_BIAS   9'h07F
`define SSSIU_QNAN       32'h7FC00000
`define SSSIU_ROOT_W     25
`define SSSIU_RST_WORD   32'h00000000

`endif

// ---- src/sssiu_isqrt.v ----
`timescale 1ns/100ps
`include "sssiu_consts.vh"

// Bit-serial restoring square root, one root bit per clock
module sssiu_isqrt #(
  parameter W = `SSSIU_ROOT_W
) (
  input  wire           clock_i,
  input  wire           rst_i,
  input  wire           start_i,
  input  wire [2*W-1:0] rad_i,
  output wire           busy_o,
  output wire           done_o,
  output wire [W-1:0]   root_o,
  output wire           rem_nz_o
);

  localparam [5:0] WC = W;

  reg [2*W-1:0] rad_q;
  reg [W:0]     rem_q;
  reg [W-1:0]   root_q;
  reg [5:0]     cnt_q;
  reg           busy_q;
  reg           done_q;

  // ****************************************************
  // Trial subtraction
  // ****************************************************
  wire [W+2:0] part = {rem_q, rad_q[2*W-1:2*W-2]};
  wire [W+2:0] trial = {1'b0, root_q, 2'b01};
  wire         ge    = (part >= trial);
  wire [W+2:0] diff  = part - trial;

  // Iteration state
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rad_q  <= {2*W{1'b0}};
      rem_q  <= {(W+1){1'b0}};
      root_q <= {W{1'b0}};
      cnt_q  <= 6'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start_i && !busy_q) begin
        rad_q  <= rad_i;
        rem_q  <= {(W+1){1'b0}};
        root_q <= {W{1'b0}};
        cnt_q  <= WC;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        rad_q  <= {rad_q[2*W-3:0], 2'b00};
        rem_q  <= ge ? diff[W:0] : part[W:0];
        root_q <= {root_q[W-2:0], ge};
        cnt_q  <= cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  assign busy_o   = busy_q;
  assign done_o   = done_q;
  assign root_o   = root_q;
  assign rem_nz_o = |rem_q; // Sticky bit
endmodule

// ---- src/sssiu_exec_unit.v ----
`timescale 1ns/100ps
`include "sssiu_consts.vh"

module sssiu_exec_unit #(
  parameter DUAL_ISSUE = 1
) (
  input  wire        clock_i,
  input  wire        rst_i,
  input  wire [31:0] slot0_instr_i,
  input  wire        slot0_valid_i,
  input  wire [31:0] slot1_instr_i,
  input  wire        slot1_valid_i,
  output wire        take0_o,
  output wire        take1_o,
  input  wire [1:0]  fp_round_mode_i,
  input  wire        fp_enable_i,
  input  wire        load_int_i,
  input  wire        load_fp_i,
  input  wire [4:0]  load_idx_i,
  input  wire [31:0] load_data_i,
  input  wire [4:0]  peek_idx_i,
  output wire [31:0] peek_int_o,
  output wire [31:0] peek_fp_o,
  output wire        int_overflow_o,
  output wire        reserved_instr_o,
  output wire        cop_unusable_o,
  output wire        fp_invalid_o,
  output wire        fp_inexact_o,
  output wire        fp_unimpl_o,
  output wire        ssnop_issued_o,
  output wire        fp_square_root_busy_o
);

  // ****************************************************
  // Integer lane: shifts, compare and trapping subtract
  // ****************************************************
  // Returns {reserved, write, overflow, dest[4:0], value[31:0]}
  function [39:0] int_exec;
    input [31:0] ins;
    input [31:0] a;
    input [31:0] b;
    reg [32:0] dif;
    reg [5:0]  fn;
    reg [4:0]  sh;
    reg [31:0] v;
    reg        we;
    reg        ovf;
    reg        ri;
    begin
      fn  = ins[`SSSIU_F_FN];
      dif = {a[31], a} - {b[31], b};
      sh  = fn[2] ? a[4:0] : ins[`SSSIU_F_SA];
      v   = 32'h0;
      we  = 1'b1;
      ovf = 1'b0;
      if (fn == `SSSIU_FN_SLL || fn == `SSSIU_FN_SRL ||
          fn == `SSSIU_FN_SRA)
        ri = |ins[`SSSIU_F_RS];
      else
        ri = |ins[`SSSIU_F_SA];
      if (ins[`SSSIU_F_OPC] != `SSSIU_OP_PRIMARY_OPCODE_ZERO_CLASS) begin
        ri = 1'b1;
      end else begin
        case (fn)
          `SSSIU_FN_SLL: begin
            v = b << sh;
          end
          `SSSIU_FN_SRL, `SSSIU_FN_SHIFT_RIGHT_LOGIC_VAR: begin
            v = b >> sh;
          end
          `SSSIU_FN_SRA, `SSSIU_FN_SHIFT_RIGHT_ARITH_VAR: begin
            v = $signed(b) >>> sh;
          end
          `SSSIU_FN_SUB: begin
            ovf = dif[32] ^ dif[31];
            v   = dif[31:0];
            we  = ~ovf;
          end
          `SSSIU_FN_UNSIGNED_LESS_THAN_SET: begin
            v = {31'h0, (a < b)};
          end
          default: begin
            ri = 1'b1;
          end
        endcase
      end
      we = we & ~ri & (|ins[`SSSIU_F_RD]);
      int_exec = {ri, we, ovf & ~ri, ins[`SSSIU_F_RD], v};
    end
  endfunction

  // ****************************************************
  // Register files
  // ****************************************************
  wire [31:0] int_rd [0:31];
  wire [31:0] fp_rd  [0:31];
  wire        w0;
  wire        w1;
  wire        fw_en;
  wire [4:0]  fw_idx;
  wire [31:0] fw_val;
  wire [39:0] ex0;
  wire [39:0] ex1;

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_ent
      localparam [4:0] IDX = gi;
      reg [31:0] int_q;
      reg [31:0] fp_q;
      // Later slot wins, load port has the lowest priority
      always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          int_q <= `SSSIU_RST_WORD;
          fp_q  <= `SSSIU_RST_WORD;
        end else begin
          if (IDX == 5'h00)
            int_q <= `SSSIU_RST_WORD;
          else if (w1 && ex1[36:32] == IDX)
            int_q <= ex1[31:0];
          else if (w0 && ex0[36:32] == IDX)
            int_q <= ex0[31:0];
          else if (load_int_i && load_idx_i == IDX)
            int_q <= load_data_i;
          if (fw_en && fw_idx == IDX)
            fp_q <= fw_val;
          else if (load_fp_i && load_idx_i == IDX)
            fp_q <= load_data_i;
        end
      end
      assign int_rd[gi] = int_q;
      assign fp_rd[gi]  = fp_q;
    end
  endgenerate

  // ****************************************************
  // Issue logic
  // ****************************************************
  wire        sq_busy;
  wire        sq_done;
  wire [24:0] sq_root;
  wire        sq_rem_nz;
  wire [31:0] s0     = slot0_instr_i;
  wire [31:0] s1     = slot1_instr_i;
  wire        dual   = (DUAL_ISSUE != 0);
  wire        cop0   = (s0[`SSSIU_F_OPC] == `SSSIU_OP_FP_COPROCESSOR_OPCODE);
  wire        fp_coprocessor_opcode   = (s1[`SSSIU_F_OPC] == `SSSIU_OP_FP_COPROCESSOR_OPCODE);
  wire        ssnop0 = (s0 == `SSSIU_SSNOP);
  wire        ssnop1 = (s1 == `SSSIU_SSNOP);
  wire        stall  = sq_busy | sq_done;
  wire [4:0]  d0     = ex0[36:32];

  assign ex0 = int_exec(s0, int_rd[s0[`SSSIU_F_RS]],
                        int_rd[s0[`SSSIU_F_RT]]);
  assign ex1 = int_exec(s1, int_rd[s1[`SSSIU_F_RS]],
                        int_rd[s1[`SSSIU_F_RT]]);

  // Second slot must not read what the first one writes
  wire raw = (|d0) && (d0 == s1[`SSSIU_F_RS] ||
                       d0 == s1[`SSSIU_F_RT]);

  // Slot 0 goes whenever the root unit is neither busy nor in its done cycle
  assign take0_o = slot0_valid_i & ~stall;

  // Pairing: no-op alone, no float pair, no pair after a trap
  assign take1_o = dual & take0_o & slot1_valid_i &
                   ~ssnop0 & ~ssnop1 &
                   ~cop0 & ~fp_coprocessor_opcode & ~raw & ~ex0[39] & ~ex0[37];

  assign w0 = take0_o & ~cop0 & ex0[38];
  assign w1 = take1_o & ex1[38];

  // ****************************************************
  // Float square root issue and coprocessor operands
  // ****************************************************
  wire [4:0]  fmt   = s0[`SSSIU_F_RS];
  wire [31:0] fsv   = fp_rd[s0[`SSSIU_F_RD]];
  wire        fsgn  = fsv[31];
  wire [7:0]  fexp  = fsv[30:23];
  wire [22:0] ffrac = fsv[22:0];
  wire [23:0] fman  = {1'b1, ffrac};
  reg         fp_start;
  reg         sp_we;
  reg  [31:0] sp_val;
  reg         f_inv;
  reg         f_unimpl;
  reg         f_cu;
  reg         f_ri;

  // Classify the operand and settle exact cases at once
  always @* begin
    fp_start = 1'b0;
    sp_we    = 1'b0;
    sp_val   = `SSSIU_QNAN;
    f_inv    = 1'b0;
    f_unimpl = 1'b0;
    f_cu     = 1'b0;
    f_ri     = 1'b0;
    if (take0_o && cop0) begin
      if (!fp_enable_i) begin
        f_cu = 1'b1;
      end else if (s0[`SSSIU_F_FN] != `SSSIU_FN_FP_SQUARE_ROOT ||
                   (|s0[`SSSIU_F_RT]) ||
                   (fmt != `SSSIU_FMT_S &&
                    fmt != `SSSIU_FMT_D)) begin
        f_ri = 1'b1;
      end else if (fmt == `SSSIU_FMT_D) begin
        f_unimpl = 1'b1;
      end else if (fexp == `SSSIU_EXP_MAX && (|ffrac)) begin
        sp_we = 1'b1;
        if (!ffrac[`SSSIU_QUIET_BIT])
          f_inv = 1'b1;
        else
          sp_val = fsv;
      end else if (fexp == 8'h00 && !(|ffrac)) begin
        sp_we  = 1'b1;
        sp_val = fsv;
      end else if (fsgn) begin
        sp_we = 1'b1;
        f_inv = 1'b1;
      end else if (fexp == 8'h00) begin
        f_unimpl = 1'b1;
      end else if (fexp == `SSSIU_EXP_MAX) begin
        sp_we  = 1'b1;
        sp_val = fsv;
      end else begin
        fp_start = 1'b1;
      end
    end
  end

  // Odd unbiased exponent takes one more radicand shift
  wire [49:0] rad = fexp[0] ? {1'b0, fman, 25'h0} : {fman, 26'h0};
  wire [8:0]  hexp = {1'b0, fexp} + `SSSIU_EXP_BIAS;

  sssiu_isqrt #(
    .W (`SSSIU_ROOT_W)
  ) u_root (
    .clock_i  (clock_i),
    .rst_i    (rst_i),
    .start_i  (fp_start),
    .rad_i    (rad),
    .busy_o   (sq_busy),
    .done_o   (sq_done),
    .root_o   (sq_root),
    .rem_nz_o (sq_rem_nz)
  );

  // ****************************************************
  // Pending root: destination, exponent, rounding mode
  // ****************************************************
  reg [4:0] pend_fd_q;
  reg [7:0] pend_exp_q;
  reg [1:0] pend_rm_q;

  // Mode is taken when the operation issues
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pend_fd_q  <= 5'h00;
      pend_exp_q <= 8'h00;
      pend_rm_q  <= `SSSIU_RM_NEAR;
    end else if (fp_start) begin
      pend_fd_q  <= s0[`SSSIU_F_SA];
      pend_exp_q <= hexp[8:1];
      pend_rm_q  <= fp_round_mode_i;
    end
  end

  // Round the 25-bit root: guard is bit 0, sticky is remainder
  wire guard = sq_root[0];
  wire inexact = guard | sq_rem_nz;
  reg  rnd_up;

  always @* begin
    case (pend_rm_q)
      `SSSIU_RM_NEAR: rnd_up = guard & (sq_rem_nz | sq_root[1]);
      `SSSIU_RM_PLUS: rnd_up = inexact;
      default:        rnd_up = 1'b0;
    endcase
  end

  // Carry out of the fraction moves into the exponent
  wire [30:0] rnd_mag = {pend_exp_q, sq_root[23:1]} +
                        {30'h0, rnd_up};

  assign fw_en  = sq_done | sp_we;
  assign fw_idx = sq_done ? pend_fd_q : s0[`SSSIU_F_SA];
  assign fw_val = sq_done ? {1'b0, rnd_mag} : sp_val;

  // ****************************************************
  // Exception pulses and read-back
  // ****************************************************
  reg        ovf_q;
  reg        ri_q;
  reg        cu_q;
  reg        inv_q;
  reg        inx_q;
  reg        uni_q;
  reg        ssn_q;
  reg [31:0] peek_int_q;
  reg [31:0] peek_fp_q;

  // Flags pulse one cycle after the causing edge
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ovf_q      <= 1'b0;
      ri_q       <= 1'b0;
      cu_q       <= 1'b0;
      inv_q      <= 1'b0;
      inx_q      <= 1'b0;
      uni_q      <= 1'b0;
      ssn_q      <= 1'b0;
      peek_int_q <= `SSSIU_RST_WORD;
      peek_fp_q  <= `SSSIU_RST_WORD;
    end else begin
      ovf_q <= (take0_o & ~cop0 & ex0[37]) |
               (take1_o & ex1[37]);
      ri_q  <= (take0_o & ~cop0 & ex0[39]) |
               (take1_o & ex1[39]) | f_ri;
      cu_q  <= f_cu;
      inv_q <= f_inv;
      inx_q <= sq_done & inexact;
      uni_q <= f_unimpl;
      ssn_q <= take0_o & ssnop0;
      peek_int_q <= int_rd[peek_idx_i];
      peek_fp_q  <= fp_rd[peek_idx_i];
    end
  end

  assign int_overflow_o   = ovf_q;
  assign reserved_instr_o = ri_q;
  assign cop_unusable_o   = cu_q;
  assign fp_invalid_o     = inv_q;
  assign fp_inexact_o     = inx_q;
  assign fp_unimpl_o      = uni_q;
  assign ssnop_issued_o   = ssn_q;
  assign fp_square_root_busy_o      = stall;
  assign peek_int_o       = peek_int_q;
  assign peek_fp_o        = peek_fp_q;
endmodule

// ---- verif/sssiu_exec_unit_sva.sv ----
`timescale 1ns/100ps
`include "sssiu_consts.vh"

// ****************************************************
// Issue and flag checker
// ****************************************************
module sssiu_exec_unit_sva (
  input wire        clock_i,
  input wire        rst_i,
  input wire [31:0] slot0_instr_i,
  input wire        slot0_valid_i,
  input wire [31:0] slot1_instr_i,
  input wire        slot1_valid_i,
  input wire        take0_o,
  input wire        take1_o,
  input wire        fp_enable_i,
  input wire        int_overflow_o,
  input wire        cop_unusable_o,
  input wire        fp_inexact_o,
  input wire        ssnop_issued_o,
  input wire        fp_square_root_busy_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  // Decoded slot0 classes
  wire       ss0 = slot0_instr_i == `SSSIU_SSNOP;
  wire       cop0 = slot0_instr_i[31:26] == `SSSIU_OP_FP_COPROCESSOR_OPCODE;
  wire       sltu0 = slot0_instr_i[31:26] == `SSSIU_OP_PRIMARY_OPCODE_ZERO_CLASS &&
                     slot0_instr_i[5:0] == `SSSIU_FN_UNSIGNED_LESS_THAN_SET;
  reg  [5:0] busy_q;

  // Counts the cycles of one root computation
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      busy_q <= 6'h00;
    end else if (fp_square_root_busy_o) begin
      busy_q <= busy_q + 6'h01;
    end else begin
      busy_q <= 6'h00;
    end
  end

  AST_REFUSE_BUSY: assert property (fp_square_root_busy_o |-> !take0_o && !take1_o)
    else $error("issue accepted while root unit busy");
  AST_TAKE_PROMPT: assert property (take0_o == (slot0_valid_i && !fp_square_root_busy_o))
    else $error("slot0 issue delayed or spurious");
  AST_SSNOP_ALONE: assert property (slot0_valid_i && ss0 |-> !take1_o)
    else $error("no-op in slot0 paired");
  AST_SSNOP_BREAK: assert property (slot1_valid_i && slot1_instr_i == `SSSIU_SSNOP |-> !take1_o)
    else $error("no-op in slot1 paired");
  AST_SSNOP_FLAG: assert property (take0_o && ss0 |=> ssnop_issued_o)
    else $error("no-op issue not reported");
  AST_SSNOP_CAUSE: assert property (ssnop_issued_o |-> $past(take0_o && ss0))
    else $error("no-op report without issue");
  AST_UNSIGNED_LESS_THAN_SET_NO_OVF: assert property (take0_o && !take1_o && sltu0 |=> !int_overflow_o)
    else $error("compare raised overflow");
  AST_ROOT_TIME: assert property ($fell(fp_square_root_busy_o) |-> busy_q == 6'h1A)
    else $error("root busy length wrong");
  AST_INEXACT_LATE: assert property (fp_inexact_o |-> $fell(fp_square_root_busy_o))
    else $error("inexact outside root completion");
  AST_UNUSABLE: assert property (take0_o && cop0 && !fp_enable_i |=> cop_unusable_o)
    else $error("unusable coprocessor not reported");
  COV_ROOT: cover property ($fell(fp_square_root_busy_o));
  COV_PAIR: cover property (take0_o && take1_o);
  COV_SSNOP: cover property (ssnop_issued_o);
endmodule

bind sssiu_exec_unit sssiu_exec_unit_sva u_sva (.clock_i, .rst_i,
  .slot0_instr_i, .slot0_valid_i, .slot1_instr_i, .slot1_valid_i,
  .take0_o, .take1_o, .fp_enable_i, .int_overflow_o, .cop_unusable_o,
  .fp_inexact_o, .ssnop_issued_o, .fp_square_root_busy_o);

// ---- verif/sssiu_exec_unit_test.sv ----
`timescale 1ns/100ps
`include "sssiu_consts.vh"
`define CHK(got, exp) \
  begin \
    num_checks = num_checks + 1; \
    if ((got) !== (exp)) begin \
      fails = fails + 1; \
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp); \
    end \
  end

module sssiu_exec_unit_test;
  localparam [6:0] F_OVF = 7'h40, F_RSV = 7'h20, F_CPU = 7'h10;
  localparam [6:0] F_INV = 7'h08, F_INX = 7'h04, F_UNI = 7'h02;
  localparam [6:0] F_SSN = 7'h01;
  reg         clock_i, rst_i, slot0_valid_i, slot1_valid_i;
  reg         fp_enable_i, load_int_i, load_fp_i;
  reg  [31:0] slot0_instr_i, slot1_instr_i, load_data_i;
  reg  [1:0]  fp_round_mode_i;
  reg  [4:0]  load_idx_i, peek_idx_i, sa;
  wire        take0_o, take1_o, int_overflow_o, reserved_instr_o;
  wire        cop_unusable_o, fp_invalid_o, fp_inexact_o, fp_unimpl_o;
  wire        ssnop_issued_o, fp_square_root_busy_o;
  wire [31:0] peek_int_o, peek_fp_o;
  wire [6:0]  flags = {int_overflow_o, reserved_instr_o, cop_unusable_o,
                       fp_invalid_o, fp_inexact_o, fp_unimpl_o,
                       ssnop_issued_o};
  reg  [65:0] exp_q [$];
  reg  [65:0] nt;
  reg  [31:0] cyc, a, b, old, e, ins;
  reg  [32:0] d;
  reg  [5:0]  fn;
  reg         imm;
  integer     fails, num_checks, i;

  sssiu_exec_unit dut (.clock_i, .rst_i, .slot0_instr_i, .slot0_valid_i,
    .slot1_instr_i, .slot1_valid_i, .take0_o, .take1_o, .fp_round_mode_i,
    .fp_enable_i, .load_int_i, .load_fp_i, .load_idx_i, .load_data_i,
    .peek_idx_i, .peek_int_o, .peek_fp_o, .int_overflow_o,
    .reserved_instr_o, .cop_unusable_o, .fp_invalid_o, .fp_inexact_o,
    .fp_unimpl_o, .ssnop_issued_o, .fp_square_root_busy_o);

  // Clock and cycle count
  always #20 clock_i = ~clock_i;
  always @(posedge clock_i) cyc <= cyc + 32'h1;

  // Compares every note that falls due in this cycle
  always @(negedge clock_i) begin
    while (exp_q.size() > 0 && exp_q[0][65:34] == cyc) begin
      nt = exp_q.pop_front();
      case (nt[33:32])
        2'h0: `CHK(peek_int_o, nt[31:0])
        2'h1: `CHK(peek_fp_o, nt[31:0])
        2'h2: `CHK(flags, nt[6:0])
        default: `CHK(take1_o, nt[0])
      endcase
    end
  end

  task step;
    begin
      @(posedge clock_i);
      #1;
    end
  endtask

  task note(input [1:0] sel, input [31:0] v);
    exp_q.push_back({cyc, sel, v});
  endtask

  task report_and_stop;
    begin
      if (exp_q.size() != 0) fails = fails + 1;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask

  // Load strobe stays up until the issue task lowers it
  task load(input fp, input [4:0] idx, input [31:0] v);
    begin
      step;
      load_int_i = !fp;
      load_fp_i = fp;
      load_idx_i = idx;
      load_data_i = v;
    end
  endtask

  // Presents two slots, waits for the take, notes pairing and flags
  task issue(input [31:0] i0, input [31:0] i1, input v1, input tk1,
             input [6:0] fl);
    integer n;
    begin
      step;
      load_int_i = 1'b0;
      load_fp_i = 1'b0;
      slot0_instr_i = i0;
      slot1_instr_i = i1;
      slot0_valid_i = 1'b1;
      slot1_valid_i = v1;
      #1;
      for (n = 0; n < 40 && take0_o !== 1'b1; n = n + 1) begin
        @(posedge clock_i);
        #2;
      end
      if (n == 40) begin
        fails = fails + 1;
        report_and_stop;
      end
      note(2'h3, {31'h0, tk1});
      step;
      slot0_valid_i = 1'b0;
      slot1_valid_i = 1'b0;
      note(2'h2, {25'h0, fl});
    end
  endtask

  // Waits for the root unit to finish, then notes its flags
  task wait_root(input [6:0] fl);
    integer n;
    begin
      for (n = 0; n < 40 && fp_square_root_busy_o !== 1'b0; n = n + 1) step;
      if (n == 40) begin
        fails = fails + 1;
        report_and_stop;
      end
      note(2'h2, {25'h0, fl});
    end
  endtask

  task peek(input [1:0] sel, input [4:0] idx, input [31:0] v);
    begin
      step;
      peek_idx_i = idx;
      step;
      note(sel, v);
    end
  endtask

  function [31:0] sq(input [4:0] fmt, input [4:0] fs, input [4:0] fd);
    sq = {`SSSIU_OP_FP_COPROCESSOR_OPCODE, fmt, 5'h00, fs, fd, `SSSIU_FN_FP_SQUARE_ROOT};
  endfunction

  // Main sequence
  initial begin
    clock_i = 1'b0;
    rst_i = 1'b1;
    {slot0_valid_i, slot1_valid_i, load_int_i, load_fp_i} = 4'h0;
    {slot0_instr_i, slot1_instr_i, load_data_i} = 96'h0;
    {fp_round_mode_i, load_idx_i, peek_idx_i} = 12'h000;
    fp_enable_i = 1'b1;
    cyc = 32'h0;
    fails = 0;
    num_checks = 0;
    void'($urandom(80));
    repeat (5) @(posedge clock_i);
    #1 rst_i = 1'b0;
    peek(2'h0, 5'd3, 32'h00000000);
    // Integer operations on boundary and random operands
    for (i = 0; i < 24; i = i + 1) begin
      a = i < 6 ? 32'h80000000 : i < 12 ? 32'h7FFFFFFF : $urandom;
      b = i < 6 ? 32'h00000001 : i < 12 ? 32'hFFFFFFFF : $urandom;
      sa = 5'($urandom);
      old = $urandom;
      d = {a[31], a} - {b[31], b};
      imm = i % 6 == 0 || i % 6 == 2;
      case (i % 6)
        0: begin fn = `SSSIU_FN_SRA; e = $signed(b) >>> sa; end
        1: begin fn = `SSSIU_FN_SHIFT_RIGHT_ARITH_VAR; e = $signed(b) >>> a[4:0]; end
        2: begin fn = `SSSIU_FN_SRL; e = b >> sa; end
        3: begin fn = `SSSIU_FN_SHIFT_RIGHT_LOGIC_VAR; e = b >> a[4:0]; end
        4: begin fn = `SSSIU_FN_UNSIGNED_LESS_THAN_SET; e = {31'h0, a < b}; end
        default: begin fn = `SSSIU_FN_SUB; e = d[32] ^ d[31] ? old : d[31:0]; end
      endcase
      ins = {6'h00, imm ? 5'h00 : 5'd1, 5'd2, 5'd3, imm ? sa : 5'h00, fn};
      load(1'b0, 5'd1, a);
      load(1'b0, 5'd2, b);
      load(1'b0, 5'd3, old);
      issue(ins, 32'h0, 1'b0, 1'b0, i % 6 == 5 && d[32] ^ d[31] ? F_OVF : 7'h00);
      peek(2'h0, 5'd3, e);
    end
    // Issue breaks around the superscalar no-op, then a shift pair and a reserved shift
    load(1'b0, 5'd1, 32'h00000000);
    load(1'b0, 5'd2, 32'h00000005);
    issue(32'h0022002B, `SSSIU_SSNOP, 1'b1, 1'b0, 7'h00);
    issue(`SSSIU_SSNOP, 32'h0022182B, 1'b1, 1'b0, F_SSN);
    issue(32'h00022042, 32'h00022883, 1'b1, 1'b1, 7'h00);
    peek(2'h0, 5'd0, 32'h00000000);
    peek(2'h0, 5'd4, 32'h00000002);
    peek(2'h0, 5'd5, 32'h00000001);
    issue(32'h00221843, 32'h0, 1'b0, 1'b0, F_RSV);
    // Square root: exact, every rounding mode, specials, faults
    load(1'b1, 5'd1, 32'h40800000);
    load(1'b1, 5'd2, 32'h40000000);
    load(1'b1, 5'd3, 32'h80000000);
    load(1'b1, 5'd4, 32'hC0800000);
    issue(sq(`SSSIU_FMT_S, 5'd1, 5'd5), 32'h0, 1'b0, 1'b0, 7'h00);
    wait_root(7'h00);
    peek(2'h1, 5'd5, 32'h40000000);
    for (i = 0; i < 4; i = i + 1) begin
      fp_round_mode_i = 2'(i);
      issue(sq(`SSSIU_FMT_S, 5'd2, 5'd6), 32'h0, 1'b0, 1'b0, 7'h00);
      wait_root(F_INX);
      peek(2'h1, 5'd6, i == 2 ? 32'h3FB504F4 : 32'h3FB504F3);
    end
    issue(sq(`SSSIU_FMT_S, 5'd3, 5'd7), 32'h0, 1'b0, 1'b0, 7'h00);
    peek(2'h1, 5'd7, 32'h80000000);
    issue(sq(`SSSIU_FMT_S, 5'd4, 5'd8), 32'h0, 1'b0, 1'b0, F_INV);
    peek(2'h1, 5'd8, `SSSIU_QNAN);
    issue(sq(`SSSIU_FMT_D, 5'd2, 5'd9), 32'h0, 1'b0, 1'b0, F_UNI);
    peek(2'h1, 5'd9, 32'h00000000);
    fp_enable_i = 1'b0;
    issue(sq(`SSSIU_FMT_S, 5'd1, 5'd10), 32'h0, 1'b0, 1'b0, F_CPU);
    peek(2'h1, 5'd10, 32'h00000000);
    step;
    step;
    report_and_stop;
  end
endmodule
